//--- dcc_channel.sv
// DMA channel control, interrupt register and AXI4-Lite slave.
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module dcc_channel (
    input  wire logic                      I_CLK,
    input  wire logic                      I_NRST,
    input  wire logic [dcc_pkg::ADDR_W-1:0] I_AWADDR,
    input  wire logic                      I_AWVALID,
    output logic                           O_AWREADY,
    input  wire logic [dcc_pkg::DATA_W-1:0] I_WDATA,
    input  wire logic [3:0]                I_WSTRB,
    input  wire logic                      I_WVALID,
    output logic                           O_WREADY,
    output logic [1:0]                     O_BRESP,
    output logic                           O_BVALID,
    input  wire logic                      I_BREADY,
    input  wire logic [dcc_pkg::ADDR_W-1:0] I_ARADDR,
    input  wire logic                      I_ARVALID,
    output logic                           O_ARREADY,
    output logic [dcc_pkg::DATA_W-1:0]     O_RDATA,
    output logic [1:0]                     O_RRESP,
    output logic                           O_RVALID,
    input  wire logic                      I_RREADY,
    input  wire logic                      I_START_EVT,
    input  wire logic                      I_ABORT_EVT,
    input  wire logic                      I_CHAIN_PREV_DONE,
    input  wire logic                      I_CHAIN_NEXT_DONE,
    input  wire logic                      I_XFER_ACK,
    input  wire logic                      I_ADDR_ERR,
    output logic                           O_XFER_REQ,
    output logic [dcc_pkg::PTR_W-1:0]      O_SRC_PTR,
    output logic [dcc_pkg::PTR_W-1:0]      O_DST_PTR,
    output logic [1:0]                     O_PRIORITY,
    output logic                           O_BLOCK_DONE,
    output logic                           O_IRQ
);
    import dcc_pkg::*;

    dcc_eng_if eng_bus ();

    logic [ADDR_W-1:0] aw_addr_reg;
    logic [DATA_W-1:0] w_data_reg;
    logic [3:0]        w_strb_reg;
    logic              aw_have_reg;
    logic              w_have_reg;
    logic              aw_have_next;
    logic              w_have_next;
    logic              aw_hs;
    logic              w_hs;
    logic              ar_hs;
    logic              wr_go;
    logic              rvalid_next;
    logic [DATA_W-1:0] rd_word;
    logic [DATA_W-1:0] wr_word;

    logic              chan_en_reg;
    logic              auto_reenable_reg;
    logic              chain_enable_reg;
    logic              chain_dir_reg;
    logic [1:0]        channel_priority_reg;
    logic              event_seen_reg;
    logic              start_reg;
    logic [FLAG_W-1:0] irq_enable_reg;
    logic [FLAG_W-1:0] irq_flag_reg;
    logic [FLAG_W-1:0] flag_set;
    logic [PTR_W-1:0]  src_size_reg;
    logic [PTR_W-1:0]  dst_size_reg;
    logic [PTR_W-1:0]  cell_size_reg;

    logic [1:0]        start_sync_reg;
    logic [1:0]        abort_sync_reg;
    logic              start_last_reg;
    logic              abort_last_reg;
    logic              start_pulse;
    logic              abort_pulse;
    logic              chain_trig;
    logic              detected;
    logic              block_done;

    function automatic logic wr_hit(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] ofs);
        wr_hit = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
    endfunction : wr_hit

    function automatic logic [DATA_W-1:0] merge(
        input logic [DATA_W-1:0] old_v,
        input logic [DATA_W-1:0] new_v,
        input logic [3:0]        strb);
        logic [DATA_W-1:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        merge = r;
    endfunction : merge

    // Bus slave handshakes.
    assign aw_hs        = I_AWVALID && O_AWREADY;
    assign w_hs         = I_WVALID && O_WREADY;
    assign ar_hs        = I_ARVALID && O_ARREADY;
    assign wr_go        = aw_have_reg && w_have_reg && !O_BVALID;
    assign aw_have_next = (aw_have_reg || aw_hs) && !wr_go;
    assign w_have_next  = (w_have_reg || w_hs) && !wr_go;
    assign rvalid_next  = (O_RVALID && !I_RREADY) || ar_hs;

    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            O_AWREADY   <= 1'b0;
            O_WREADY    <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg  <= '0;
            w_strb_reg  <= 4'h0;
        end else begin
            aw_have_reg <= aw_have_next;
            w_have_reg  <= w_have_next;
            O_AWREADY   <= !aw_have_next;
            O_WREADY    <= !w_have_next;
            if (aw_hs) begin
                aw_addr_reg <= I_AWADDR;
            end
            if (w_hs) begin
                w_data_reg <= I_WDATA;
                w_strb_reg <= I_WSTRB;
            end
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            O_BVALID <= 1'b0;
            O_BRESP  <= RESP_OKAY;
        end else if (wr_go) begin
            O_BVALID <= 1'b1;
            O_BRESP  <= (wr_hit(aw_addr_reg, OFS_CTRL)
                      || wr_hit(aw_addr_reg, OFS_IRQ)
                      || wr_hit(aw_addr_reg, OFS_SRC_SIZE)
                      || wr_hit(aw_addr_reg, OFS_SRC_PTR)
                      || wr_hit(aw_addr_reg, OFS_DST_SIZE)
                      || wr_hit(aw_addr_reg, OFS_DST_PTR)
                      || wr_hit(aw_addr_reg, OFS_CELL_SIZE))
                      ? RESP_OKAY : RESP_DECERR;
        end else if (I_BREADY) begin
            O_BVALID <= 1'b0;
        end
    end

    // Read data; unimplemented bits and addresses read as zero.
    always_comb begin
        rd_word = '0;
        if (wr_hit(I_ARADDR, OFS_CTRL)) begin
            rd_word[CTL_PRI_LSB +: 2] = channel_priority_reg;
            rd_word[CTL_EVT_BIT]      = event_seen_reg;
            rd_word[CTL_AEN_BIT]      = auto_reenable_reg;
            rd_word[CTL_CHN_BIT]      = chain_enable_reg;
            rd_word[CTL_EN_BIT]       = chan_en_reg;
            rd_word[CTL_CDIR_BIT]     = chain_dir_reg;
            rd_word[CTL_BUSY_BIT]     = eng_bus.busy;
        end else if (wr_hit(I_ARADDR, OFS_IRQ)) begin
            rd_word[IRQ_IE_LSB +: FLAG_W] = irq_enable_reg;
            rd_word[IRQ_IF_LSB +: FLAG_W] = irq_flag_reg;
        end else if (wr_hit(I_ARADDR, OFS_SRC_SIZE)) begin
            rd_word[PTR_W-1:0] = src_size_reg;
        end else if (wr_hit(I_ARADDR, OFS_SRC_PTR)) begin
            rd_word[PTR_W-1:0] = eng_bus.src_ptr;
        end else if (wr_hit(I_ARADDR, OFS_DST_SIZE)) begin
            rd_word[PTR_W-1:0] = dst_size_reg;
        end else if (wr_hit(I_ARADDR, OFS_DST_PTR)) begin
            rd_word[PTR_W-1:0] = eng_bus.dst_ptr;
        end else if (wr_hit(I_ARADDR, OFS_CELL_SIZE)) begin
            rd_word[PTR_W-1:0] = cell_size_reg;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            O_RVALID  <= 1'b0;
            O_ARREADY <= 1'b0;
            O_RDATA   <= '0;
            O_RRESP   <= RESP_OKAY;
        end else begin
            O_RVALID  <= rvalid_next;
            O_ARREADY <= !rvalid_next;
            if (ar_hs) begin
                O_RDATA <= rd_word;
                O_RRESP <= (I_ARADDR[ADDR_W-1:2] <= OFS_CELL_SIZE[ADDR_W-1:2]
                         && I_ARADDR[3:2] == 2'h0) ? RESP_OKAY : RESP_DECERR;
            end
        end
    end

    // Start and abort pin events pass two flip-flops before any logic reads them; chain and address-error pins are read directly.
    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            start_sync_reg <= 2'h0;
            abort_sync_reg <= 2'h0;
            start_last_reg <= 1'b0;
            abort_last_reg <= 1'b0;
        end else begin
            start_sync_reg <= {start_sync_reg[0], I_START_EVT};
            abort_sync_reg <= {abort_sync_reg[0], I_ABORT_EVT};
            start_last_reg <= start_sync_reg[1];
            abort_last_reg <= abort_sync_reg[1];
        end
    end

    assign start_pulse = start_sync_reg[1] && !start_last_reg;
    assign abort_pulse = (abort_sync_reg[1] && !abort_last_reg) || I_ADDR_ERR;
    assign chain_trig  = chain_enable_reg && (chain_dir_reg
                         ? I_CHAIN_NEXT_DONE : I_CHAIN_PREV_DONE);
    assign detected    = chan_en_reg && (start_pulse || chain_trig);
    assign block_done  = eng_bus.events[F_BLOCK];
    assign wr_word     = merge(32'h00000000, w_data_reg, w_strb_reg);

    // Control register and its hardware updates.
    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            chan_en_reg          <= 1'b0;
            auto_reenable_reg    <= 1'b0;
            chain_enable_reg     <= 1'b0;
            chain_dir_reg        <= 1'b0;
            channel_priority_reg <= PRI_RST;
        end else begin
            if (wr_go && wr_hit(aw_addr_reg, OFS_CTRL) && w_strb_reg[0]) begin
                chan_en_reg          <= wr_word[CTL_EN_BIT];
                auto_reenable_reg    <= wr_word[CTL_AEN_BIT];
                chain_enable_reg     <= wr_word[CTL_CHN_BIT];
                channel_priority_reg <= wr_word[CTL_PRI_LSB +: 2];
            end else if (block_done && !auto_reenable_reg) begin
                chan_en_reg <= 1'b0;
            end
            if (wr_go && wr_hit(aw_addr_reg, OFS_CTRL) && w_strb_reg[1]) begin
                chain_dir_reg <= wr_word[CTL_CDIR_BIT];
            end
        end
    end

    // A new event wins over the clear taken by a starting run.
    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            event_seen_reg <= 1'b0;
            start_reg      <= 1'b0;
        end else begin
            if (detected) begin
                event_seen_reg <= 1'b1;
            end else if (start_reg || !chan_en_reg) begin
                event_seen_reg <= 1'b0;
            end
            start_reg <= chan_en_reg && event_seen_reg && !eng_bus.busy
                         && !start_reg;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            src_size_reg  <= SIZE_RST;
            dst_size_reg  <= SIZE_RST;
            cell_size_reg <= SIZE_RST;
        end else if (wr_go) begin
            if (wr_hit(aw_addr_reg, OFS_SRC_SIZE)) begin
                src_size_reg <= PTR_W'(merge({16'h0000, src_size_reg},
                                             w_data_reg, w_strb_reg));
            end
            if (wr_hit(aw_addr_reg, OFS_DST_SIZE)) begin
                dst_size_reg <= PTR_W'(merge({16'h0000, dst_size_reg},
                                             w_data_reg, w_strb_reg));
            end
            if (wr_hit(aw_addr_reg, OFS_CELL_SIZE)) begin
                cell_size_reg <= PTR_W'(merge({16'h0000, cell_size_reg},
                                              w_data_reg, w_strb_reg));
            end
        end
    end

    // Interrupt enables and sticky flags; set wins over a write of zero.
    assign flag_set = eng_bus.events
                    | {6'h00, abort_pulse, 1'b0}
                    | {7'h00, I_ADDR_ERR};

    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            irq_enable_reg <= FLAGS_RST;
            irq_flag_reg   <= FLAGS_RST;
        end else begin
            if (wr_go && wr_hit(aw_addr_reg, OFS_IRQ) && w_strb_reg[2]) begin
                irq_enable_reg <= w_data_reg[IRQ_IE_LSB +: FLAG_W];
            end
            if (wr_go && wr_hit(aw_addr_reg, OFS_IRQ) && w_strb_reg[0]) begin
                irq_flag_reg <= (irq_flag_reg
                                & w_data_reg[IRQ_IF_LSB +: FLAG_W])
                                | flag_set;
            end else begin
                irq_flag_reg <= irq_flag_reg | flag_set;
            end
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            O_IRQ        <= 1'b0;
            O_PRIORITY   <= PRI_RST;
            O_BLOCK_DONE <= 1'b0;
        end else begin
            O_IRQ        <= |(irq_flag_reg & irq_enable_reg);
            O_PRIORITY   <= channel_priority_reg;
            O_BLOCK_DONE <= block_done;
        end
    end

    assign eng_bus.start     = start_reg;
    assign eng_bus.stop      = !chan_en_reg;
    assign eng_bus.abort     = abort_pulse;
    assign eng_bus.ack       = I_XFER_ACK;
    assign eng_bus.src_size  = src_size_reg;
    assign eng_bus.dst_size  = dst_size_reg;
    assign eng_bus.cell_size = cell_size_reg;
    assign O_XFER_REQ        = eng_bus.req;
    assign O_SRC_PTR         = eng_bus.src_ptr;
    assign O_DST_PTR         = eng_bus.dst_ptr;

    dcc_engine u_engine (
        .i_clk  (I_CLK),
        .i_nrst (I_NRST),
        .eng    (eng_bus.eng)
    );
endmodule : dcc_channel

//--- dcc_pkg.sv
// Constants and types shared by the DMA channel control files.
package dcc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int PTR_W  = 16;
    localparam int FLAG_W = 8;

    localparam logic [ADDR_W-1:0] OFS_CTRL      = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_IRQ       = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_SRC_SIZE  = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_SRC_PTR   = 8'h30;
    localparam logic [ADDR_W-1:0] OFS_DST_SIZE  = 8'h40;
    localparam logic [ADDR_W-1:0] OFS_DST_PTR   = 8'h50;
    localparam logic [ADDR_W-1:0] OFS_CELL_SIZE = 8'h60;

    localparam int CTL_PRI_LSB  = 0;
    localparam int CTL_EVT_BIT  = 2;
    localparam int CTL_AEN_BIT  = 4;
    localparam int CTL_CHN_BIT  = 5;
    localparam int CTL_EN_BIT   = 7;
    localparam int CTL_CDIR_BIT = 8;
    localparam int CTL_BUSY_BIT = 15;

    localparam int IRQ_IE_LSB = 16;
    localparam int IRQ_IF_LSB = 0;
    localparam int F_SRC_DONE = 7;
    localparam int F_SRC_HALF = 6;
    localparam int F_DST_DONE = 5;
    localparam int F_DST_HALF = 4;
    localparam int F_BLOCK    = 3;
    localparam int F_CELL     = 2;
    localparam int F_ABORT    = 1;
    localparam int F_ADDR_ERR = 0;

    localparam logic [DATA_W-1:0] IRQ_IMPL_MASK = 32'h00FF00FF;
    localparam logic [PTR_W-1:0]  SIZE_RST      = 16'h0000;
    localparam logic [FLAG_W-1:0] FLAGS_RST     = 8'h00;
    localparam logic [1:0]        PRI_RST       = 2'h0;
    localparam logic [1:0]        RESP_OKAY     = 2'h0;
    localparam logic [1:0]        RESP_DECERR   = 2'h3;

    typedef enum logic {ENG_IDLE, ENG_XFER} dcc_eng_state_t;
endpackage : dcc_pkg

//--- dcc_eng_if.sv
// Signals between the channel controller and its transfer engine.
`timescale 1ns/1ps
interface dcc_eng_if;
    import dcc_pkg::*;
    logic              start;
    logic              stop;
    logic              abort;
    logic              ack;
    logic              busy;
    logic              req;
    logic [PTR_W-1:0]  src_size;
    logic [PTR_W-1:0]  dst_size;
    logic [PTR_W-1:0]  cell_size;
    logic [PTR_W-1:0]  src_ptr;
    logic [PTR_W-1:0]  dst_ptr;
    logic [FLAG_W-1:0] events;

    modport ctl (output start, stop, abort, ack, src_size, dst_size,
                 cell_size, input busy, req, src_ptr, dst_ptr, events);
    modport eng (input start, stop, abort, ack, src_size, dst_size,
                 cell_size, output busy, req, src_ptr, dst_ptr, events);
endinterface : dcc_eng_if

//--- dcc_engine.sv
// Transfer engine: walks the source and destination pointers.
`timescale 1ns/1ps
module dcc_engine (
    input wire logic i_clk,
    input wire logic i_nrst,
    dcc_eng_if.eng   eng
);
    import dcc_pkg::*;

    dcc_eng_state_t   state_reg;
    dcc_eng_state_t   state_next;
    logic [PTR_W-1:0] cell_cnt_reg;
    logic [PTR_W-1:0] src_next;
    logic [PTR_W-1:0] dst_next;
    logic [PTR_W-1:0] cell_next;
    logic             take;
    logic             dst_end;
    logic             src_end;

    assign take      = (state_reg == ENG_XFER) && eng.req && eng.ack;
    assign src_next  = eng.src_ptr + 16'h0001;
    assign dst_next  = eng.dst_ptr + 16'h0001;
    assign cell_next = cell_cnt_reg + 16'h0001;
    assign src_end   = (src_next == eng.src_size);
    assign dst_end   = (dst_next == eng.dst_size);
    assign eng.busy  = (state_reg == ENG_XFER);

    // A stop only ends the run once the pending item is acknowledged.
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ENG_IDLE: begin
                if (eng.start && !eng.abort) begin
                    state_next = ENG_XFER;
                end
            end
            ENG_XFER: begin
                if (eng.abort) begin
                    state_next = ENG_IDLE;
                end else if (take && (dst_end || eng.stop)) begin
                    state_next = ENG_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            state_reg <= ENG_IDLE;
            eng.req   <= 1'b0;
        end else begin
            state_reg <= state_next;
            eng.req   <= (state_next == ENG_XFER);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst || eng.abort) begin
            eng.src_ptr  <= SIZE_RST;
            eng.dst_ptr  <= SIZE_RST;
            cell_cnt_reg <= SIZE_RST;
        end else if (take) begin
            eng.src_ptr  <= src_end ? SIZE_RST : src_next;
            eng.dst_ptr  <= dst_end ? SIZE_RST : dst_next;
            cell_cnt_reg <= (cell_next == eng.cell_size || dst_end)
                            ? SIZE_RST : cell_next;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            eng.events <= FLAGS_RST;
        end else begin
            eng.events             <= FLAGS_RST;
            eng.events[F_SRC_DONE] <= take && src_end;
            eng.events[F_SRC_HALF] <= take &&
                (src_next == (eng.src_size >> 1));
            eng.events[F_DST_DONE] <= take && dst_end;
            eng.events[F_DST_HALF] <= take &&
                (dst_next == (eng.dst_size >> 1));
            eng.events[F_BLOCK]    <= take && dst_end;
            eng.events[F_CELL]     <= take &&
                (cell_next == eng.cell_size || dst_end);
        end
    end
endmodule : dcc_engine

//--- dcc_channel_sva.sv
// Port-level assertions for the DMA channel controller.
`timescale 1ns/1ps
module dcc_channel_sva
    import dcc_pkg::*;
(
    input wire logic        I_CLK,
    input wire logic        I_NRST,
    input wire logic [7:0]  I_ARADDR,
    input wire logic        I_ARVALID,
    input wire logic        O_ARREADY,
    input wire logic        O_AWREADY,
    input wire logic        O_WREADY,
    input wire logic        O_BVALID,
    input wire logic [31:0] O_RDATA,
    input wire logic        O_RVALID,
    input wire logic        I_XFER_ACK,
    input wire logic        I_ADDR_ERR,
    input wire logic        O_XFER_REQ,
    input wire logic [15:0] O_SRC_PTR,
    input wire logic [15:0] O_DST_PTR,
    input wire logic        O_BLOCK_DONE
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_NRST);
    sequence s_item;
        O_XFER_REQ && I_XFER_ACK;
    endsequence
    sequence s_ar;
        O_ARREADY && I_ARVALID;
    endsequence
    property p_irq_rsvd;
        s_ar ##0 (I_ARADDR == OFS_IRQ) |=> (O_RDATA & ~IRQ_IMPL_MASK) == 0;
    endproperty
    a_irq_rsvd: assert property (p_irq_rsvd)
        else $error("reserved interrupt bits read nonzero");
    property p_src_step;
        s_item |=> (O_SRC_PTR == $past(O_SRC_PTR) + 16'h1)
            || (O_SRC_PTR == 16'h0);
    endproperty
    a_src_step: assert property (p_src_step)
        else $error("source pointer did not step");
    property p_ptr_hold;
        !(O_XFER_REQ && I_XFER_ACK) && !I_ADDR_ERR && !$past(I_ADDR_ERR)
            |=> $stable(O_SRC_PTR) && $stable(O_DST_PTR);
    endproperty
    a_ptr_hold: assert property (p_ptr_hold)
        else $error("pointer moved without an item");
    property p_req_fall;
        $fell(O_XFER_REQ) |-> $past(I_XFER_ACK) || $past(I_ADDR_ERR);
    endproperty
    a_req_fall: assert property (p_req_fall)
        else $error("request dropped before the item finished");
    property p_blk_pulse;
        O_BLOCK_DONE |-> !O_XFER_REQ ##1 !O_BLOCK_DONE;
    endproperty
    a_blk_pulse: assert property (p_blk_pulse)
        else $error("block done pulse malformed");
    property p_blk_cause;
        $rose(O_BLOCK_DONE) |-> $past(I_XFER_ACK) || $past(I_XFER_ACK, 2);
    endproperty
    a_blk_cause: assert property (p_blk_cause)
        else $error("block done without a final item");
    property p_b_wait;
        $rose(O_BVALID) |-> !$past(O_AWREADY) && !$past(O_WREADY);
    endproperty
    a_b_wait: assert property (p_b_wait)
        else $error("write response without both channels taken");
    property p_r_answer;
        s_ar |=> O_RVALID && !O_ARREADY;
    endproperty
    a_r_answer: assert property (p_r_answer)
        else $error("read data late");
endmodule : dcc_channel_sva
bind dcc_channel dcc_channel_sva u_sva (.I_CLK(I_CLK), .I_NRST(I_NRST),
    .I_ARADDR(I_ARADDR), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY),
    .O_AWREADY(O_AWREADY), .O_WREADY(O_WREADY), .O_BVALID(O_BVALID),
    .O_RDATA(O_RDATA), .O_RVALID(O_RVALID), .I_XFER_ACK(I_XFER_ACK),
    .I_ADDR_ERR(I_ADDR_ERR), .O_XFER_REQ(O_XFER_REQ),
    .O_SRC_PTR(O_SRC_PTR), .O_DST_PTR(O_DST_PTR),
    .O_BLOCK_DONE(O_BLOCK_DONE));

//--- dcc_mem_model.sv
// Behavioural model of the bus memory that answers item requests.
`timescale 1ns/1ps
module dcc_mem_model (
    input  wire logic       i_clk,
    input  wire logic       i_nrst,
    input  wire logic       i_req,
    input  wire logic [3:0] i_delay,
    input  wire logic       i_fail,
    output logic            o_ack,
    output logic            o_addr_err
);
    logic [3:0] cnt_reg;
    always_ff @(posedge i_clk) begin
        if (!i_nrst || !i_req || o_ack) begin
            cnt_reg <= 4'h0;
        end else if (cnt_reg != 4'hF) begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end
    // A zero wait keeps ack up for back-to-back items.
    always_ff @(posedge i_clk) begin
        o_ack      <= i_nrst && i_req && !i_fail && cnt_reg >= i_delay
                      && !(o_ack && i_delay != 4'h0);
        o_addr_err <= i_nrst && i_req && i_fail && cnt_reg == i_delay;
    end
endmodule : dcc_mem_model

//--- dcc_channel_bench.sv
// Self-checking bench for the DMA channel controller.
`timescale 1ns/1ps
module dcc_channel_bench;
    import dcc_pkg::*;
    logic        clk, nrst, awv, wv, arv, st, chp, fail;
    logic        awr, wrdy, bv, arr, rv, req, bd, irq, ack, aerr;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, v;
    logic [1:0]  bresp, rresp, r, pri;
    logic [15:0] sp, dp;
    logic [3:0]  dly;
    int          failures, checks_done, i, blocks;
    dcc_channel dut (.I_CLK(clk), .I_NRST(nrst), .I_AWADDR(awaddr),
        .I_AWVALID(awv), .O_AWREADY(awr), .I_WDATA(wdata),
        .I_WSTRB(4'hF), .I_WVALID(wv), .O_WREADY(wrdy), .O_BRESP(bresp),
        .O_BVALID(bv), .I_BREADY(1'b1), .I_ARADDR(araddr),
        .I_ARVALID(arv), .O_ARREADY(arr), .O_RDATA(rdata),
        .O_RRESP(rresp), .O_RVALID(rv), .I_RREADY(1'b1),
        .I_START_EVT(st), .I_ABORT_EVT(1'b0), .I_CHAIN_PREV_DONE(chp),
        .I_CHAIN_NEXT_DONE(1'b0), .I_XFER_ACK(ack), .I_ADDR_ERR(aerr),
        .O_XFER_REQ(req), .O_SRC_PTR(sp), .O_DST_PTR(dp),
        .O_PRIORITY(pri), .O_BLOCK_DONE(bd), .O_IRQ(irq));
    dcc_mem_model mem (.i_clk(clk), .i_nrst(nrst), .i_req(req),
        .i_delay(dly), .i_fail(fail), .o_ack(ack), .o_addr_err(aerr));
    always @(posedge clk) begin
        if (bd) blocks <= blocks + 1;
    end
    task automatic chk(input string n, input logic [31:0] s, e);
        checks_done++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a; wdata <= d; awv <= 1'b1; wv <= 1'b1;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
        end while (!bv);
        r = bresp;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        araddr <= a; arv <= 1'b1;
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        v = rdata;
        r = rresp;
    endtask : rd
    task automatic go;
        st <= 1'b1;
        repeat (6) @(posedge clk);
        st <= 1'b0;
        do rd(OFS_CTRL); while (v[15]);
    endtask : go
    task automatic report_and_stop;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        report_and_stop();
    end
    initial begin
        {nrst, awv, wv, arv, st, chp, fail} = '0;
        awaddr = '0; araddr = '0; wdata = '0; dly = 4'h2;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd(OFS_IRQ);
        chk("irq_rst", v, 32'h0);
        wr(OFS_IRQ, 32'hFFFFFFFF);
        rd(OFS_IRQ);
        chk("irq_ie", v, 32'h00FF0000);
        wr(8'h04, 32'h1);
        chk("decerr", r, RESP_DECERR);
        rd(8'h70);
        chk("rd_decerr", r, RESP_DECERR);
        for (i = 0; i < 4; i++) begin
            wr(OFS_CTRL, 32'(i));
            chk("prio", pri, i[1:0]);
        end
        wr(OFS_SRC_SIZE, 32'h4);
        wr(OFS_DST_SIZE, 32'h4);
        wr(OFS_CELL_SIZE, 32'h2);
        wr(OFS_CTRL, 32'h80);
        go();
        rd(OFS_CTRL);
        chk("auto_off", v & 32'h80, 32'h0);
        rd(OFS_IRQ);
        chk("flags", v & 32'h00FF00EF, 32'h00FF00EC);
        chk("irq_on", irq, 1'b1);
        wr(OFS_IRQ, 32'h00FF0000);
        chk("irq_off", irq, 1'b0);
        wr(OFS_IRQ, 32'h0);
        wr(OFS_CTRL, 32'h90);
        dly <= 4'h0;
        go();
        rd(OFS_CTRL);
        chk("auto_on", v & 32'h80, 32'h80);
        chk("masked", irq, 1'b0);
        wr(OFS_IRQ, 32'h000800FF);
        chk("unmasked", irq, 1'b1);
        wr(OFS_IRQ, 32'h0);
        wr(OFS_CTRL, 32'h80);
        chp <= 1'b1;
        @(posedge clk);
        chp <= 1'b0;
        repeat (6) @(posedge clk);
        rd(OFS_CTRL);
        chk("no_chain", v & 32'h8004, 32'h0);
        wr(OFS_CTRL, 32'hA0);
        chp <= 1'b1;
        @(posedge clk);
        chp <= 1'b0;
        repeat (4) @(posedge clk);
        do rd(OFS_CTRL); while (v[15]);
        rd(OFS_IRQ);
        chk("chained", v & 32'h8, 32'h8);
        wr(OFS_IRQ, 32'h0);
        wr(OFS_DST_SIZE, 32'h8);
        wr(OFS_CTRL, 32'h80);
        dly <= 4'h3;
        st <= 1'b1;
        repeat (14) @(posedge clk);
        st <= 1'b0;
        wr(OFS_CTRL, 32'h0);
        do rd(OFS_CTRL); while (v[15]);
        chk("susp_req", req, 1'b0);
        rd(OFS_IRQ);
        chk("susp_flag", v & 32'h8, 32'h0);
        wr(OFS_IRQ, 32'h00030000);
        fail <= 1'b1;
        wr(OFS_CTRL, 32'h80);
        go();
        rd(OFS_IRQ);
        chk("abort", v & 32'h3, 32'h3);
        chk("abort_irq", irq, 1'b1);
        chk("abort_ptr", dp, 16'h0);
        chk("abort_src", sp, 16'h0);
        chk("blocks", blocks, 3);
        report_and_stop();
    end
endmodule : dcc_channel_bench
